// ---- shared/nfw_map.svh ----
`ifndef NFW_MAP_SVH
`define NFW_MAP_SVH
// ****************************************
// host command register map
// ****************************************
`define NFW_REG_CTRL        4'h0
`define NFW_REG_ADDR        4'h1
`define NFW_REG_WDATA       4'h2
`define NFW_REG_STATUS      4'h3
`define NFW_REG_RDATA       4'h4
`define NFW_REG_BOOT        4'h5
// ctrl field positions
`define NFW_CTRL_GO_BIT     4
`define NFW_CTRL_WP_BIT     5
`define NFW_CTRL_RST_BIT    6
`define NFW_CTRL_CMD_LSB    0
// status field positions
`define NFW_ST_BUSY_BIT     0
`define NFW_ST_DONE_BIT     1
`define NFW_ST_FAIL_BIT     2
`define NFW_ST_PROT_BIT     3
// ****************************************
// command words and addresses
// ****************************************
`define NFW_A_5555          20'h05555
`define NFW_A_2AAA          20'h02AAA
`define NFW_A_55            20'h00055
`define NFW_A_MFR           20'h00000
`define NFW_A_DEV           20'h00001
`define NFW_D_AA            16'h00AA
`define NFW_D_55            16'h0055
`define NFW_D_PROG          16'h00A0
`define NFW_D_ERASE         16'h0080
`define NFW_D_SECT          16'h0030
`define NFW_D_BLK           16'h0050
`define NFW_D_CHIP          16'h0010
`define NFW_D_QUERY         16'h0098
`define NFW_D_IDENT         16'h0090
`define NFW_D_EXIT          16'h00F0
`define NFW_D_SUSP          16'h00B0
// boot block ranges
`define NFW_BOOT_BOT_LO     20'h00000
`define NFW_BOOT_BOT_HI     20'h07FFF
`define NFW_BOOT_TOP_LO     20'hF8000
`define NFW_BOOT_TOP_HI     20'hFFFFF
// ****************************************
// timing
// ****************************************
`define NFW_CLK_NS          50
`define NFW_STROBE_NS       100
`define NFW_STROBE_CYC      ((`NFW_STROBE_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS)
`define NFW_SETTLE_NS       1000
`define NFW_SETTLE_CYC      ((`NFW_SETTLE_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS)
`define NFW_RP_NS           500
`define NFW_RP_CYC          ((`NFW_RP_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS)
`define NFW_RHR_NS          1000
`define NFW_RHR_CYC         ((`NFW_RHR_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS)
`define NFW_RC_NS           100
`define NFW_RC_CYC          ((`NFW_RC_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS)
`define NFW_POLL_MAX        16'h4000
`endif

// ---- shared/nfw_pkg.sv ----
package nfw_pkg;
  typedef enum logic [3:0] {
    NFW_OP_READ, NFW_OP_PROG, NFW_OP_SECT, NFW_OP_BLK, NFW_OP_CHIP,
    NFW_OP_QLEG, NFW_OP_QGEN, NFW_OP_IDENT, NFW_OP_EXIT, NFW_OP_SUSP,
    NFW_OP_RESUME, NFW_OP_HWRST
  } nfw_op_t;
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_n;
    logic        wp_n;
    logic [19:0] addr;
  } nfw_pins_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } nfw_cycle_t;
endpackage

// ---- hw/nfw_bus_cycle.sv ----
`include "nfw_map.svh"
// one write or read bus cycle on the flash pins
module nfw_bus_cycle (
  input  wire logic               core_clk_i, // clock
  input  wire logic               sys_rst_i,  // sync reset
  input  wire logic               start_i,    // begin a cycle
  input  wire logic               write_i,    // 1 write, 0 read
  input  wire nfw_pkg::nfw_cycle_t cyc_i,     // address and data
  input  wire logic [15:0]        dq_i,       // flash data in
  output logic                    ce_n_o,     // chip select
  output logic                    oe_n_o,     // output gate
  output logic                    we_n_o,     // write strobe
  output logic                    dq_oe_o,    // data drive enable
  output logic [19:0]             addr_o,     // address pins
  output logic [15:0]             dq_o,       // data pins out
  output logic [15:0]             rdata_o,    // captured read word
  output logic                    done_o      // cycle finished pulse
);
  logic [3:0] cnt_q;
  logic       act_q;
  logic       wr_q;

  // strobes held well above the glitch filter width
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      act_q   <= 1'b0;
      cnt_q   <= 4'h0;
      wr_q    <= 1'b0;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      dq_oe_o <= 1'b0;
      addr_o  <= 20'h00000;
      dq_o    <= 16'h0000;
      rdata_o <= 16'h0000;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !act_q) begin
        act_q   <= 1'b1;
        cnt_q   <= 4'(`NFW_STROBE_CYC + 1);
        wr_q    <= write_i;
        addr_o  <= cyc_i.addr;
        dq_o    <= cyc_i.data;
        dq_oe_o <= write_i;
        ce_n_o  <= 1'b0;
        oe_n_o  <= write_i; // output gate high for writes
        we_n_o  <= 1'b1;
      end else if (act_q) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'(`NFW_STROBE_CYC + 1)) begin
          we_n_o <= !wr_q;
        end else if (cnt_q == 4'h1) begin
          we_n_o <= 1'b1;
          if (!wr_q) begin
            rdata_o <= dq_i;
          end
        end else if (cnt_q == 4'h0) begin
          act_q   <= 1'b0;
          ce_n_o  <= 1'b1;
          oe_n_o  <= 1'b1;
          dq_oe_o <= 1'b0;
          done_o  <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- hw/nfw_host.sv ----
`include "nfw_map.svh"
module nfw_host (
  input  wire logic        core_clk_i, // clock
  input  wire logic        sys_rst_i,  // sync reset
  input  wire logic [3:0]  reg_addr_i, // register address
  input  wire logic [31:0] reg_wdata_i,// register write data
  input  wire logic        reg_wr_i,   // write strobe
  input  wire logic        reg_rd_i,   // read strobe
  output logic      [31:0] reg_rdata_o,// read data, next cycle
  input  wire logic [15:0] dq_i,       // flash data in
  output logic      [15:0] dq_o,       // flash data out
  output logic             dq_oe_o,    // flash data drive enable
  output logic      [19:0] addr_o,     // flash address
  output logic             ce_n_o,     // chip select, low active
  output logic             oe_n_o,     // output gate, low active
  output logic             we_n_o,     // write strobe, low active
  output logic             rst_n_o,    // flash reset, low active
  output logic             wp_n_o      // write protect, low active
);
  typedef enum {
    ST_IDLE, ST_WRITE, ST_POLL, ST_SETTLE, ST_VERIFY, ST_RST, ST_RHR, ST_READ
  } nfw_st_t;

  nfw_st_t               st_q;
  nfw_pkg::nfw_op_t      op_q;
  nfw_pkg::nfw_cycle_t   seq_q [6];
  nfw_pkg::nfw_cycle_t   cur;
  logic [2:0]            nseq_q;
  logic [2:0]            idx_q;
  logic [19:0]           addr_q;
  logic [15:0]           wdata_q;
  logic                  top_q;
  logic                  busy_q;
  logic                  done_q;
  logic                  fail_q;
  logic                  prot_q;
  logic [15:0]           rdata_q;
  logic [15:0]           tmr_q;
  logic [15:0]           prev_q;
  logic [1:0]            ok_q;
  logic                  start;
  logic                  write;
  logic [15:0]           cyc_rdata;
  logic                  cyc_done;
  logic                  rst_busy_q;
  logic                  erase_op;

  function automatic logic in_boot(input logic [19:0] a, input logic top);
    if (top) begin
      in_boot = (a >= `NFW_BOOT_TOP_LO) && (a <= `NFW_BOOT_TOP_HI);
    end else begin
      in_boot = (a >= `NFW_BOOT_BOT_LO) && (a <= `NFW_BOOT_BOT_HI);
    end
  endfunction

  // a completed word: polling true for program, one for erase
  function automatic logic status_ok(input logic [15:0] d, input logic [15:0] p,
                                     input logic er, input logic [15:0] w);
    if (er) begin
      status_ok = d[7] && (d[6] == p[6]);
    end else begin
      status_ok = (d[7] == w[7]) && (d[6] == p[6]);
    end
  endfunction

  assign erase_op = (op_q == nfw_pkg::NFW_OP_SECT) || (op_q == nfw_pkg::NFW_OP_BLK) ||
                    (op_q == nfw_pkg::NFW_OP_CHIP);
  assign start = (st_q == ST_WRITE) || (st_q == ST_POLL) || (st_q == ST_VERIFY) ||
                 (st_q == ST_READ);
  assign write = (st_q == ST_WRITE);
  always_comb begin
    cur = seq_q[idx_q];
    if (st_q != ST_WRITE) begin
      cur.addr = addr_q; // status reads at the written location
      cur.data = 16'h0000;
    end
  end

  nfw_bus_cycle u_cyc (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (start && !cyc_done),
    .write_i    (write),
    .cyc_i      (cur),
    .dq_i       (dq_i),
    .ce_n_o     (ce_n_o),
    .oe_n_o     (oe_n_o),
    .we_n_o     (we_n_o),
    .dq_oe_o    (dq_oe_o),
    .addr_o     (addr_o),
    .dq_o       (dq_o),
    .rdata_o    (cyc_rdata),
    .done_o     (cyc_done)
  );

  // ****************************************
  // command sequence build
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 6; i++) begin
        seq_q[i] <= '0;
      end
      nseq_q <= 3'h0;
    end else if (st_q == ST_IDLE && reg_wr_i && reg_addr_i == `NFW_REG_CTRL &&
                 reg_wdata_i[`NFW_CTRL_GO_BIT]) begin
      // unlock prefix, upper byte always static zero
      seq_q[0] <= {`NFW_A_5555, `NFW_D_AA};
      seq_q[1] <= {`NFW_A_2AAA, `NFW_D_55};
      seq_q[3] <= {`NFW_A_5555, `NFW_D_AA};
      seq_q[4] <= {`NFW_A_2AAA, `NFW_D_55};
      nseq_q   <= 3'h3;
      unique case (nfw_pkg::nfw_op_t'(reg_wdata_i[3:0]))
        nfw_pkg::NFW_OP_PROG: begin
          seq_q[2] <= {`NFW_A_5555, `NFW_D_PROG};
          seq_q[3] <= {addr_q, wdata_q};
          nseq_q   <= 3'h4;
        end
        nfw_pkg::NFW_OP_SECT, nfw_pkg::NFW_OP_BLK, nfw_pkg::NFW_OP_CHIP: begin
          seq_q[2] <= {`NFW_A_5555, `NFW_D_ERASE};
          nseq_q   <= 3'h6;
          if (reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_SECT)) begin
            seq_q[5] <= {addr_q, `NFW_D_SECT};
          end else if (reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_BLK)) begin
            seq_q[5] <= {addr_q, `NFW_D_BLK};
          end else begin
            seq_q[5] <= {`NFW_A_5555, `NFW_D_CHIP};
          end
        end
        nfw_pkg::NFW_OP_QLEG:  seq_q[2] <= {`NFW_A_5555, `NFW_D_QUERY};
        nfw_pkg::NFW_OP_IDENT: seq_q[2] <= {`NFW_A_5555, `NFW_D_IDENT};
        nfw_pkg::NFW_OP_EXIT:  seq_q[2] <= {`NFW_A_5555, `NFW_D_EXIT};
        nfw_pkg::NFW_OP_QGEN: begin
          seq_q[0] <= {`NFW_A_55, `NFW_D_QUERY};
          nseq_q   <= 3'h1;
        end
        nfw_pkg::NFW_OP_SUSP: begin
          seq_q[0] <= {addr_q, `NFW_D_SUSP};
          nseq_q   <= 3'h1;
        end
        nfw_pkg::NFW_OP_RESUME: begin
          seq_q[0] <= {addr_q, `NFW_D_SECT};
          nseq_q   <= 3'h1;
        end
        default: nseq_q <= 3'h0;
      endcase
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q    <= ST_IDLE;
      op_q    <= nfw_pkg::NFW_OP_READ;
      idx_q   <= 3'h0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
      prot_q  <= 1'b0;
      tmr_q   <= 16'h0000;
      prev_q  <= 16'h0000;
      ok_q    <= 2'h0;
      rdata_q <= 16'h0000;
      rst_n_o <= 1'b1;
      rst_busy_q <= 1'b0;
    end else begin
      if (reg_rd_i && reg_addr_i == `NFW_REG_STATUS) begin
        done_q <= 1'b0;
      end
      unique case (st_q)
        ST_IDLE: begin
          if (reg_wr_i && reg_addr_i == `NFW_REG_CTRL && reg_wdata_i[`NFW_CTRL_GO_BIT]) begin
            op_q   <= nfw_pkg::nfw_op_t'(reg_wdata_i[3:0]);
            idx_q  <= 3'h0;
            fail_q <= 1'b0;
            prot_q <= 1'b0;
            busy_q <= 1'b1;
            tmr_q  <= 16'h0000;
            if (reg_wdata_i[`NFW_CTRL_RST_BIT] ||
                reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_HWRST)) begin
              st_q    <= ST_RST;
              rst_n_o <= 1'b0;
            end else if (reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_READ)) begin
              st_q <= ST_READ;
            end else if (reg_wdata_i[`NFW_CTRL_WP_BIT] &&
                         (reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_CHIP) ||
                          ((reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_PROG) ||
                            reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_SECT) ||
                            reg_wdata_i[3:0] == 4'(nfw_pkg::NFW_OP_BLK)) &&
                           in_boot(addr_q, top_q)))) begin
              busy_q <= 1'b0; // device would ignore it
              done_q <= 1'b1;
              prot_q <= 1'b1;
            end else begin
              st_q <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (cyc_done) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q + 3'h1 >= nseq_q) begin
              // polling valid after fourth or sixth strobe
              if (op_q == nfw_pkg::NFW_OP_PROG || erase_op) begin
                st_q   <= ST_POLL;
                prev_q <= {16{erase_op}} ^ ~wdata_q;
              end else begin
                st_q   <= ST_IDLE; // ident/query/exit take effect at once
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
          end
        end
        ST_POLL: begin
          if (cyc_done) begin
            prev_q <= cyc_rdata;
            tmr_q  <= tmr_q + 16'h0001;
            if (status_ok(cyc_rdata, prev_q, erase_op, wdata_q)) begin
              st_q  <= ST_SETTLE;
              tmr_q <= 16'h0000;
              ok_q  <= 2'h0;
            end else if (tmr_q == `NFW_POLL_MAX) begin
              st_q   <= ST_IDLE;
              busy_q <= 1'b0;
              fail_q <= 1'b1;
              done_q <= 1'b1;
            end
          end
        end
        ST_SETTLE: begin
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'(`NFW_SETTLE_CYC)) begin
            st_q <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          if (cyc_done) begin
            prev_q <= cyc_rdata;
            if (!status_ok(cyc_rdata, prev_q, erase_op, wdata_q)) begin
              st_q  <= ST_POLL; // rejection stands
              tmr_q <= 16'h0000;
            end else if (ok_q == 2'h1) begin
              st_q    <= ST_IDLE;
              busy_q  <= 1'b0;
              done_q  <= 1'b1;
              rdata_q <= cyc_rdata;
            end else begin
              ok_q <= ok_q + 2'h1;
            end
          end
        end
        ST_RST: begin
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'(`NFW_RP_CYC)) begin
            rst_n_o <= 1'b1;
            tmr_q   <= 16'h0000;
            st_q    <= ST_RHR;
          end
        end
        ST_RHR: begin
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == 16'(`NFW_RHR_CYC)) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            fail_q <= rst_busy_q; // rst_busy_q is always low here, since a reset only starts from ST_IDLE
          end
        end
        ST_READ: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            st_q    <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
        end
      endcase
      rst_busy_q <= (st_q == ST_POLL) || (st_q == ST_SETTLE) || (st_q == ST_VERIFY) ||
                    (st_q == ST_RST && rst_busy_q);
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_q  <= 20'h00000;
      wdata_q <= 16'h0000;
      top_q   <= 1'b0;
      wp_n_o  <= 1'b1;
    end else if (reg_wr_i && st_q == ST_IDLE) begin
      unique case (reg_addr_i)
        `NFW_REG_ADDR:  addr_q  <= reg_wdata_i[19:0];
        `NFW_REG_WDATA: wdata_q <= reg_wdata_i[15:0];
        `NFW_REG_BOOT:  top_q   <= reg_wdata_i[0];
        `NFW_REG_CTRL:  wp_n_o  <= !reg_wdata_i[`NFW_CTRL_WP_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `NFW_REG_CTRL:   reg_rdata_o <= {26'h0, !wp_n_o, 1'b0, 4'(op_q)};
        `NFW_REG_ADDR:   reg_rdata_o <= {12'h000, addr_q};
        `NFW_REG_WDATA:  reg_rdata_o <= {16'h0000, wdata_q};
        `NFW_REG_STATUS: reg_rdata_o <= {28'h0, prot_q, fail_q, done_q, busy_q};
        `NFW_REG_RDATA:  reg_rdata_o <= {16'h0000, rdata_q};
        `NFW_REG_BOOT:   reg_rdata_o <= {31'h0, top_q};
        default:         reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end
endmodule

// ---- verif/nfw_host_sva.sv ----
`include "nfw_map.svh"
module nfw_host_sva (
  input wire logic        core_clk_i,  // clock
  input wire logic        sys_rst_i,   // reset
  input wire logic [15:0] dq_o,        // data out
  input wire logic        dq_oe_o,     // data enable
  input wire logic [19:0] addr_o,      // address
  input wire logic        ce_n_o,      // select
  input wire logic        oe_n_o,      // output gate
  input wire logic        we_n_o,      // write strobe
  input wire logic        rst_n_o,     // flash reset
  input wire logic        wp_n_o       // protect
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin protocol checks
  // ****************************************
  int unsigned low_q, rec_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || rst_n_o) low_q <= 0;
    else low_q <= low_q + 1;
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) rec_q <= 255;
    else if (!rst_n_o) rec_q <= 0;
    else if (rec_q < 255) rec_q <= rec_q + 1;
  end
  AST_WE_SEL: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
    else $error("strobe without select or with gate low");
  AST_WE_DRV: assert property (!we_n_o |-> dq_oe_o && rst_n_o)
    else $error("strobe while data undriven");
  AST_OE_FREE: assert property (!oe_n_o |-> !dq_oe_o && we_n_o)
    else $error("bus driven during read");
  AST_WE_WIDTH: assert property ($fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o)
    else $error("strobe width wrong");
  AST_WE_HOLD: assert property (!we_n_o && !$past(we_n_o) |->
    $stable(addr_o) && $stable(dq_o)) else $error("address or data moved in strobe");
  AST_UPPER: assert property (!we_n_o && addr_o inside {`NFW_A_5555, `NFW_A_2AAA}
    |-> dq_o[15:8] == 8'h00) else $error("upper byte not static low");
  AST_RP: assert property ($rose(rst_n_o) |-> low_q >= `NFW_RP_CYC)
    else $error("reset pulse too short");
  AST_RHR: assert property ($fell(ce_n_o) |-> rec_q >= `NFW_RHR_CYC)
    else $error("access inside reset recovery");
  AST_RST_IDLE: assert property (!rst_n_o |-> ce_n_o && we_n_o)
    else $error("bus cycle during reset");
  AST_WP_STABLE: assert property (!ce_n_o |-> $stable(wp_n_o))
    else $error("protect moved in bus cycle");
  cover property ($rose(rst_n_o));
  cover property (!we_n_o && dq_o == `NFW_D_QUERY);
  cover property (!we_n_o && !wp_n_o);
endmodule

bind nfw_host nfw_host_sva nfw_host_sva_i (.core_clk_i, .sys_rst_i, .dq_o, .dq_oe_o, .addr_o,
  .ce_n_o, .oe_n_o, .we_n_o, .rst_n_o, .wp_n_o);

// ---- verif/nfw_flash_model.sv ----
module nfw_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00C3, // arbitrary maker code
  parameter logic [15:0] DEV_CODE = 16'h5A17, // arbitrary part code
  parameter logic [15:0] QRY_WORD = 16'h0051, // query data
  parameter time         PROG_T   = 3000,     // program time
  parameter time         ERASE_T  = 6000      // erase time
) (
  input  wire logic        ce_n_i,  // select
  input  wire logic        oe_n_i,  // output gate
  input  wire logic        we_n_i,  // write strobe
  input  wire logic        rst_n_i, // reset
  input  wire logic        wp_n_i,  // protect
  input  wire logic        top_i,   // top variant
  input  wire logic [19:0] addr_i,  // address
  input  wire logic [15:0] dq_i,    // bus in
  output logic      [15:0] dq_o     // bus out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // behavioural flash
  // ****************************************
  logic [15:0] mem [logic [19:0]];
  logic [19:0] kq [$];
  logic [19:0] wa;
  logic [19:0] em;
  logic [15:0] wd;
  int          step = 0;
  int          mode = 0;
  int          n_resets = 0;
  bit          busy = 0;
  bit          er = 0;
  bit          tog = 0;
  time         t_fall = 0;
  time         t_done = 0;
  event        go_ev;
  initial dq_o = 16'h0000;
  function automatic logic [15:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic bit boot(input logic [19:0] a);
    return top_i ? a >= 20'hF8000 : a <= 20'h07FFF;
  endfunction
  function automatic logic [15:0] view(input logic [19:0] a);
    logic [15:0] v;
    v = rd(a);
    if (busy) begin
      v = 16'h0000;
      v[7] = er ? 1'b0 : ~wd[7];
      v[6] = tog;
      v[2] = er & tog;
      tog = ~tog;
    end else if (mode == 1) v = (a == 0) ? MFR_CODE : (a == 1) ? DEV_CODE : 16'h0000;
    else if (mode == 2) v = QRY_WORD;
    else if ($time - t_done < 1000) v[6:0] = ~v[6:0];
    return v;
  endfunction
  task automatic launch(input bit e, input logic [19:0] a, input logic [15:0] d,
                        input logic [19:0] m);
    er = e;
    wa = a;
    wd = d;
    em = m;
    busy = 1;
    -> go_ev;
  endtask
  task automatic take(input logic [19:0] a, input logic [15:0] d);
    bit u5;
    u5 = a == 20'h05555;
    case (step)
      0: begin
        if (a == 20'h00055 && d == 16'h0098) mode = 2;
        step = u5 && d == 16'h00AA;
      end
      1, 4: step = (a == 20'h02AAA && d == 16'h0055) ? step + 1 : 0;
      3: step = (u5 && d == 16'h00AA) ? 4 : 0;
      2: begin
        step = (u5 && d == 16'h00A0) ? 6 : (u5 && d == 16'h0080) ? 3 : 0;
        if (u5 && d == 16'h0090) mode = 1;
        if (u5 && d == 16'h0098) mode = 2;
        if (u5 && d == 16'h00F0) mode = 0;
      end
      6: begin
        step = 0;
        if (wp_n_i || !boot(a)) launch(0, a, d, 20'h00000);
      end
      5: begin
        step = 0;
        em = (d == 16'h0030) ? 20'hFF800 : (d == 16'h0050) ? 20'hF8000 : 20'h00000;
        if (d inside {16'h0030, 16'h0050, 16'h0010} && (wp_n_i || !(d == 16'h0010 || boot(a))))
          launch(1, a, d, em);
      end
      default: step = 0;
    endcase
  endtask
  always @(negedge we_n_i) t_fall = $time;
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && rst_n_i && !busy && $time - t_fall >= 5)
      take(addr_i, dq_i);
  end
  always @(go_ev) begin : run_op
    #(er ? ERASE_T : PROG_T);
    kq.delete();
    foreach (mem[k]) if (er && (k & em) == (wa & em)) kq.push_back(k);
    foreach (kq[i]) mem.delete(kq[i]);
    if (!er) mem[wa] = rd(wa) & wd;
    t_done = $time;
    busy = 0;
  end
  always @(negedge rst_n_i) begin
    disable run_op;
    busy = 0;
    step = 0;
    mode = 0;
    n_resets++;
  end
  always @(negedge oe_n_i) begin
    #1;
    if (!ce_n_i) dq_o = view(addr_i);
  end
  // released bus shows the inverse of the last word
  always @(posedge oe_n_i) dq_o = ~dq_o;
endmodule

// ---- verif/nfw_host_test.sv ----
`include "nfw_map.svh"
module nfw_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bench
  // ****************************************
  logic        core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, top;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] h_dq, f_dq;
  logic [19:0] addr;
  logic        h_oe, ce_n, oe_n, we_n, rst_n, wp_n;
  int          n_fail, total_checks;
  wire logic [15:0] bus = h_oe ? h_dq : f_dq;
  nfw_host nfw_host_i (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .dq_i(bus), .dq_o(h_dq), .dq_oe_o(h_oe), .addr_o(addr),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .rst_n_o(rst_n), .wp_n_o(wp_n));
  nfw_flash_model nfw_flash_model_i (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .rst_n_i(rst_n), .wp_n_i(wp_n), .top_i(top), .addr_i(addr), .dq_i(bus), .dq_o(f_dq));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic issue(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d,
                       input logic wp);
    wr(`NFW_REG_ADDR, {12'h000, a});
    wr(`NFW_REG_WDATA, {16'h0000, d});
    wr(`NFW_REG_BOOT, {31'h0, top});
    wr(`NFW_REG_CTRL, {25'h0, 1'b0, wp, 1'b1, c});
  endtask
  task automatic idle(output logic [31:0] st);
    st = 32'h1;
    for (int i = 0; i < 30000 && st[0] !== 1'b0; i++) rd(`NFW_REG_STATUS, st);
  endtask
  task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d,
                    input logic wp, input logic [3:0] e);
    logic [31:0] st;
    issue(c, a, d, wp);
    idle(st);
    chk("status", {28'h0, e}, {28'h0, st[3:0]});
  endtask
  task automatic peek(input logic [19:0] a, input logic [15:0] e);
    logic [31:0] v;
    op(nfw_pkg::NFW_OP_READ, a, 16'h0000, 1'b0, 4'h2);
    rd(`NFW_REG_RDATA, v);
    chk("read word", {16'h0, e}, v);
  endtask
  task automatic t_program;
    op(nfw_pkg::NFW_OP_PROG, 20'h01234, 16'h5A3C, 1'b0, 4'h2);
    peek(20'h01234, 16'h5A3C);
    chk("cell", 32'h5A3C, {16'h0, nfw_flash_model_i.rd(20'h01234)});
    $display("test program finished");
  endtask
  task automatic t_refuse;
    logic [31:0] st;
    issue(nfw_pkg::NFW_OP_PROG, 20'h02000, 16'h1111, 1'b0);
    wr(`NFW_REG_WDATA, 32'h0);
    wr(4'hE, 32'hFFFF_FFFF);
    idle(st);
    chk("status", 32'h2, {28'h0, st[3:0]});
    peek(20'h02000, 16'h1111);
    $display("test refuse finished");
  endtask
  task automatic t_erase;
    logic [3:0] c [3] = '{nfw_pkg::NFW_OP_SECT, nfw_pkg::NFW_OP_BLK, nfw_pkg::NFW_OP_CHIP};
    for (int i = 0; i < 3; i++) begin
      op(nfw_pkg::NFW_OP_PROG, 20'h01234, 16'h0F0F, 1'b0, 4'h2);
      op(c[i], 20'h01234, 16'h0000, 1'b0, 4'h2);
      peek(20'h01234, 16'hFFFF);
    end
    $display("test erase finished");
  endtask
  task automatic t_protect;
    logic [19:0] pa [4] = '{20'h07FFF, 20'h08000, 20'hF8000, 20'hF7FFF};
    for (int i = 0; i < 4; i++) begin
      top = i >= 2;
      op(nfw_pkg::NFW_OP_PROG, pa[i], 16'h5A3C, 1'b1, i[0] ? 4'h2 : 4'hA);
      chk("cell", i[0] ? 32'h5A3C : 32'hFFFF, {16'h0, nfw_flash_model_i.rd(pa[i])});
    end
    op(nfw_pkg::NFW_OP_CHIP, 20'h05555, 16'h0000, 1'b1, 4'hA);
    chk("cell", 32'h5A3C, {16'h0, nfw_flash_model_i.rd(20'hF7FFF)});
    $display("test protect finished");
  endtask
  task automatic t_ident;
    op(nfw_pkg::NFW_OP_IDENT, 20'h00000, 16'h0000, 1'b0, 4'h2);
    peek(20'h00000, nfw_flash_model_i.MFR_CODE);
    peek(20'h00001, nfw_flash_model_i.DEV_CODE);
    op(nfw_pkg::NFW_OP_EXIT, 20'h00000, 16'h0000, 1'b0, 4'h2);
    peek(20'h00000, 16'hFFFF);
    op(nfw_pkg::NFW_OP_SUSP, 20'h08000, 16'h0000, 1'b0, 4'h2);
    op(nfw_pkg::NFW_OP_RESUME, 20'h08000, 16'h0000, 1'b0, 4'h2);
    $display("test ident finished");
  endtask
  task automatic t_query;
    for (int j = 0; j < 2; j++) begin
      op(j ? nfw_pkg::NFW_OP_QGEN : nfw_pkg::NFW_OP_QLEG, 0, 0, 1'b0, 4'h2);
      peek(20'h00010, nfw_flash_model_i.QRY_WORD);
      op(nfw_pkg::NFW_OP_EXIT, 20'h00000, 16'h0000, 1'b0, 4'h2);
      peek(20'h00010, 16'hFFFF);
    end
    $display("test query finished");
  endtask
  task automatic t_reset;
    op(nfw_pkg::NFW_OP_HWRST, 20'h00000, 16'h0000, 1'b0, 4'h2);
    chk("resets", 32'h1, nfw_flash_model_i.n_resets);
    peek(20'h08000, 16'h5A3C);
    $display("test reset finished");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    top = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_program;
    t_refuse;
    t_erase;
    t_protect;
    t_ident;
    t_query;
    t_reset;
    stop_test;
  end
  initial begin
    #4000000;
    n_fail++;
    stop_test;
  end
endmodule
